//--- include/ftcl_pkg.sv
// Purpose: shared constants and types of the flight termination command logic
// Assumes: AXI4-Lite register port, 32-bit data, 200 MHz clock
// Notes:   all offsets are byte addresses
package ftcl_pkg;

  localparam int unsigned CLK_HZ       = 200_000_000;
  localparam int unsigned VALID_ON_US10 = 199000;
  localparam int unsigned VALID_OFF_US = 100;
  localparam int unsigned VALID_ON_CYC  = (VALID_ON_US10 / 10) * (CLK_HZ / 1_000_000);
  localparam int unsigned VALID_OFF_CYC = VALID_OFF_US * (CLK_HZ / 1_000_000);

  localparam logic [7:0] OFF_CTRL    = 8'h00;
  localparam logic [7:0] OFF_STATUS  = 8'h04;
  localparam logic [7:0] OFF_IRQ_ST  = 8'h08;
  localparam logic [7:0] OFF_IRQ_MSK = 8'h0C;
  localparam logic [7:0] OFF_COUNTER = 8'h10;
  localparam logic [7:0] OFF_KEY_ID  = 8'h14;
  localparam logic [7:0] OFF_CONFIG  = 8'h18;
  localparam logic [7:0] OFF_FS      = 8'h1C;
  localparam logic [7:0] OFF_WRITES  = 8'h20;

  localparam logic [31:0] KEY_ZERO_SENTINEL = 32'h0000_0000; // arbitrary value
  localparam logic [3:0]  STD_CFG_SLOT      = 4'h0;
  localparam logic [15:0] STD_LINK_LOSS_S   = 16'h0005;
  localparam logic [15:0] STD_POWER_LOSS_DV = 16'h00E6;
  localparam logic [15:0] WRITES_INIT       = 16'hFFFF;

  localparam int unsigned CF_WIRELESS = 0;
  localparam int unsigned CF_FAILSAFE = 1;
  localparam int unsigned CF_TERM_CV  = 2;
  localparam int unsigned CF_CNT_EN   = 3;

  localparam int unsigned EV_ARM  = 0;
  localparam int unsigned EV_TERM = 1;
  localparam int unsigned EV_OPT  = 2;
  localparam int unsigned EV_MON  = 3;
  localparam int unsigned EV_CHK  = 4;
  localparam int unsigned EV_MSG  = 5;
  localparam int unsigned EV_NUM  = 6;

  typedef enum logic [3:0] {
    FTCL_CMD_NOP,
    FTCL_CMD_ARM,
    FTCL_CMD_TERM,
    FTCL_CMD_OPT,
    FTCL_CMD_MON,
    FTCL_CMD_CLEAR_LATCHED_OUTPUTS_CMD,
    FTCL_CMD_CNT_CLEAR,
    FTCL_CMD_CFG_SELECT,
    FTCL_CMD_CFG_COMMIT
  } ftcl_cmd_t;

  typedef struct packed {
    ftcl_cmd_t   cmd;
    logic        check_channel;
    logic [15:0] counter;
    logic [3:0]  cfg_slot;
  } ftcl_msg_t;

  typedef struct packed {
    logic        arm;
    logic        term;
    logic        opt;
    logic        mon;
    logic        chk;
    logic        valid;
  } ftcl_out_t;

endpackage

//--- verilog/ftcl_core.sv
// Purpose: command output logic of a flight termination receiver
// Assumes: messages arrive already decoded and authenticated, one-cycle msg_valid
// Notes:   registers over AXI4-Lite; one level interrupt
// Function
// - no command output is raised except by the command-to-output mapping.
// - arm, terminate and optional outputs latch on their command until cleared.
// - terminate drives arm and terminate only when arm is already latched.
// - latches clear only on power cycle, clear_latched_outputs_cmd, or select plus commit changing config.
// - monitor and check-channel outputs pulse once per message and never latch.
// - counter-clear with the next expected counter value zeroes the counter.
// - with wireless on, select 0 then commit 0 leaves the counter at zero.
// - standard reload with active config 0 zeroes the counter.
// - after key zeroize the key identifier reads a fixed sentinel.
// - with key zeroized no message, even a check-channel no-op, gets a response.
// - the loaded key identifier is readable.
// - remaining storage write cycles are kept and readable.
// - standard config: slot 0, wireless on, failsafe off, constant voltage, counter on, 5 s.
// - standard power-loss failsafe threshold is 23.0 volts.
// - each decoded message arriving while command valid is idle drives it on 19.9 ms then off 100 us; messages during on or off are not queued.
`timescale 1ns/1ps
module ftcl_core
  import ftcl_pkg::*;
#(
  parameter int unsigned VALID_ON  = VALID_ON_CYC,
  parameter int unsigned VALID_OFF = VALID_OFF_CYC
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        msg_valid,
  input  wire ftcl_msg_t   msg,
  input  wire logic        key_load,
  input  wire logic [31:0] key_load_id,
  input  wire logic        key_zeroize,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output ftcl_out_t        outs,
  output logic             irq
);

  if (VALID_ON < 1 || VALID_OFF < 1 || VALID_ON > 32'h7FFF_FFFF) begin : g_bad_timing
    $error("ftcl_core: bad command valid timing");
  end

  typedef enum logic [1:0] {FTCL_V_IDLE, FTCL_V_ON, FTCL_V_OFF} ftcl_vst_t;

  // command state
  ftcl_out_t    outs_r, outs_nxt;
  logic [15:0]  cnt_r, cnt_nxt;
  logic [3:0]   cfg_r, cfg_nxt;
  logic [3:0]   pend_r, pend_nxt;
  logic         pend_v_r, pend_v_nxt;
  logic [3:0]   flags_r, flags_nxt;
  logic [15:0]  link_loss_r, link_loss_nxt;
  logic [15:0]  pwr_thr_r, pwr_thr_nxt;
  logic [15:0]  writes_r, writes_nxt;
  logic [31:0]  key_r, key_nxt;
  logic         keyed_r, keyed_nxt;
  ftcl_vst_t    vst_r, vst_nxt;
  logic [31:0]  vcnt_r, vcnt_nxt;
  logic         vreq_r, vreq_nxt;
  logic         vout_nxt;
  logic [EV_NUM-1:0] ist_r, ist_nxt, imsk_r, imsk_nxt, ev;
  logic         irq_r, irq_nxt;

  // bus state
  logic         awr_r, awr_nxt, wr_r, wr_nxt, bv_r, bv_nxt;
  logic         awrdy_r, awrdy_nxt, wrdy_r, wrdy_nxt;
  logic [7:0]   awa_r, awa_nxt;
  logic [31:0]  wd_r, wd_nxt;
  logic         ar_r, ar_nxt, rv_r, rv_nxt;
  logic [31:0]  rd_r, rd_nxt;
  logic [1:0]   brsp_r, brsp_nxt, rrsp_r, rrsp_nxt;

  logic         do_wr, ctrl_wr, accept;
  logic         ctl_clear_latched_outputs_cmd, ctl_std, ctl_rst_cfg;
  logic [31:0]  rdv;
  logic         rmap;

  assign do_wr   = awr_r && wr_r && !bv_r;
  assign ctrl_wr = do_wr && awa_r == OFF_CTRL;
  assign ctl_clear_latched_outputs_cmd = ctrl_wr && wd_r[0];
  assign ctl_std     = ctrl_wr && wd_r[1];
  assign ctl_rst_cfg = ctrl_wr && wd_r[2];
  assign accept  = msg_valid && keyed_r;

  always_comb begin
    outs_nxt      = outs_r;
    outs_nxt.valid = vout_nxt;
    outs_nxt.mon  = 1'b0;
    outs_nxt.chk  = 1'b0;
    cnt_nxt       = cnt_r;
    cfg_nxt       = cfg_r;
    pend_nxt      = pend_r;
    pend_v_nxt    = pend_v_r;
    flags_nxt     = flags_r;
    link_loss_nxt = link_loss_r;
    pwr_thr_nxt   = pwr_thr_r;
    writes_nxt    = writes_r;
    key_nxt       = key_r;
    keyed_nxt     = keyed_r;
    vreq_nxt      = 1'b0;
    ev            = '0;
    if (key_zeroize) begin
      key_nxt   = KEY_ZERO_SENTINEL;
      keyed_nxt = 1'b0;
    end else if (key_load) begin
      key_nxt   = key_load_id;
      keyed_nxt = 1'b1;
    end
    if (ctl_clear_latched_outputs_cmd) begin
      outs_nxt.arm  = 1'b0;
      outs_nxt.term = 1'b0;
      outs_nxt.opt  = 1'b0;
    end
    if (ctl_std) begin
      cfg_nxt       = STD_CFG_SLOT;
      flags_nxt     = 4'hF & ~(4'h1 << CF_FAILSAFE);
      link_loss_nxt = STD_LINK_LOSS_S;
      pwr_thr_nxt   = STD_POWER_LOSS_DV;
      if (writes_r != 16'h0000) begin
        writes_nxt = writes_r - 16'h0001;
      end
    end
    if (ctl_rst_cfg || ctl_std) begin
      cfg_nxt = 4'h0;
      cnt_nxt = 16'h0000;
    end
    if (accept) begin
      vreq_nxt = 1'b1;
      ev[EV_MSG] = 1'b1;
      if (flags_r[CF_CNT_EN]) begin
        cnt_nxt = cnt_r + 16'h0001;
      end
      if (msg.check_channel) begin
        outs_nxt.chk = 1'b1;
        ev[EV_CHK]   = 1'b1;
      end
      case (msg.cmd)
        FTCL_CMD_ARM: begin
          outs_nxt.arm = 1'b1;
          ev[EV_ARM]   = 1'b1;
        end
        FTCL_CMD_TERM: begin
          if (outs_r.arm) begin
            outs_nxt.term = 1'b1;
            ev[EV_TERM]   = 1'b1;
          end
        end
        FTCL_CMD_OPT: begin
          outs_nxt.opt = 1'b1;
          ev[EV_OPT]   = 1'b1;
        end
        FTCL_CMD_MON: begin
          outs_nxt.mon = 1'b1;
          ev[EV_MON]   = 1'b1;
        end
        FTCL_CMD_CLEAR_LATCHED_OUTPUTS_CMD: begin
          outs_nxt.arm  = 1'b0;
          outs_nxt.term = 1'b0;
          outs_nxt.opt  = 1'b0;
        end
        FTCL_CMD_CNT_CLEAR: begin
          if (msg.counter == cnt_r + 16'h0001) begin
            cnt_nxt = 16'h0000;
          end
        end
        FTCL_CMD_CFG_SELECT: begin
          if (flags_r[CF_WIRELESS]) begin
            pend_nxt   = msg.cfg_slot;
            pend_v_nxt = 1'b1;
          end
        end
        FTCL_CMD_CFG_COMMIT: begin
          if (flags_r[CF_WIRELESS] && pend_v_r && pend_r == msg.cfg_slot) begin
            pend_v_nxt = 1'b0;
            cnt_nxt    = 16'h0000;
            if (msg.cfg_slot != cfg_r) begin
              cfg_nxt       = msg.cfg_slot;
              outs_nxt.arm  = 1'b0;
              outs_nxt.term = 1'b0;
              outs_nxt.opt  = 1'b0;
            end
          end
        end
        default: begin
        end
      endcase
    end
  end

  // command valid pulse: on for VALID_ON cycles then off for VALID_OFF cycles
  always_comb begin
    vst_nxt       = vst_r;
    vcnt_nxt      = vcnt_r;
    vout_nxt      = 1'b0;
    case (vst_r)
      FTCL_V_IDLE: begin
        if (vreq_r) begin
          vst_nxt  = FTCL_V_ON;
          vcnt_nxt = 32'(VALID_ON - 1);
        end
      end
      FTCL_V_ON: begin
        vout_nxt = 1'b1;
        if (vcnt_r == 32'h0) begin
          vst_nxt  = FTCL_V_OFF;
          vcnt_nxt = 32'(VALID_OFF - 1);
        end else begin
          vcnt_nxt = vcnt_r - 32'h1;
        end
      end
      FTCL_V_OFF: begin
        if (vcnt_r == 32'h0) begin
          vst_nxt = FTCL_V_IDLE;
        end else begin
          vcnt_nxt = vcnt_r - 32'h1;
        end
      end
      default: begin
        vst_nxt = FTCL_V_IDLE;
      end
    endcase
  end

  // interrupts: sticky, write one to clear, set wins
  always_comb begin
    ist_nxt  = ist_r;
    imsk_nxt = imsk_r;
    if (do_wr && awa_r == OFF_IRQ_ST) begin
      ist_nxt = ist_r & ~wd_r[EV_NUM-1:0];
    end
    if (do_wr && awa_r == OFF_IRQ_MSK) begin
      imsk_nxt = wd_r[EV_NUM-1:0];
    end
    ist_nxt = ist_nxt | ev;
    irq_nxt = |(ist_nxt & imsk_nxt);
  end

  // register read mux
  always_comb begin
    rdv  = 32'h0;
    rmap = 1'b1;
    case (s_axi_araddr[7:0])
      OFF_CTRL:    rdv = 32'h0;
      OFF_STATUS:  rdv = {25'h0, keyed_r, outs_r.valid, pend_v_r, 1'b0,
                          outs_r.opt, outs_r.term, outs_r.arm};
      OFF_IRQ_ST:  rdv = {{(32-EV_NUM){1'b0}}, ist_r};
      OFF_IRQ_MSK: rdv = {{(32-EV_NUM){1'b0}}, imsk_r};
      OFF_COUNTER: rdv = {16'h0, cnt_r};
      OFF_KEY_ID:  rdv = key_r;
      OFF_CONFIG:  rdv = {20'h0, pend_r, flags_r, cfg_r};
      OFF_FS:      rdv = {pwr_thr_r, link_loss_r};
      OFF_WRITES:  rdv = {16'h0, writes_r};
      default:     rmap = 1'b0;
    endcase
  end

  // AXI4-Lite slave: address and data held until both present, then one response
  always_comb begin
    awr_nxt  = awr_r;
    awa_nxt  = awa_r;
    wr_nxt   = wr_r;
    wd_nxt   = wd_r;
    bv_nxt   = bv_r;
    brsp_nxt = brsp_r;
    ar_nxt   = 1'b0;
    rv_nxt   = rv_r;
    rd_nxt   = rd_r;
    rrsp_nxt = rrsp_r;
    if (s_axi_awvalid && !awr_r) begin
      awr_nxt = 1'b1;
      awa_nxt = s_axi_awaddr[7:0];
    end
    if (s_axi_wvalid && !wr_r) begin
      wr_nxt = 1'b1;
      wd_nxt = s_axi_wdata;
    end
    if (do_wr) begin
      bv_nxt   = 1'b1;
      brsp_nxt = (awa_r <= OFF_WRITES && awa_r[1:0] == 2'b00) ? 2'b00 : 2'b10;
    end
    if (bv_r && s_axi_bready) begin
      bv_nxt  = 1'b0;
      awr_nxt = 1'b0;
      wr_nxt  = 1'b0;
    end
    awrdy_nxt = !awr_nxt;
    wrdy_nxt  = !wr_nxt;
    if (s_axi_arvalid && !rv_r && !ar_r) begin
      ar_nxt   = 1'b1;
      rv_nxt   = 1'b1;
      rd_nxt   = rmap ? rdv : 32'h0;
      rrsp_nxt = rmap ? 2'b00 : 2'b10;
    end
    if (rv_r && s_axi_rready) begin
      rv_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      outs_r      <= '0;
      cnt_r       <= 16'h0000;
      cfg_r       <= STD_CFG_SLOT;
      pend_r      <= 4'h0;
      pend_v_r    <= 1'b0;
      flags_r     <= 4'hF & ~(4'h1 << CF_FAILSAFE);
      link_loss_r <= STD_LINK_LOSS_S;
      pwr_thr_r   <= STD_POWER_LOSS_DV;
      writes_r    <= WRITES_INIT;
      key_r       <= KEY_ZERO_SENTINEL;
      keyed_r     <= 1'b0;
      vst_r       <= FTCL_V_IDLE;
      vcnt_r      <= 32'h0;
      vreq_r      <= 1'b0;
      ist_r       <= '0;
      imsk_r      <= '0;
      irq_r       <= 1'b0;
      awr_r       <= 1'b0;
      awrdy_r     <= 1'b1;
      awa_r       <= 8'h00;
      wr_r        <= 1'b0;
      wrdy_r      <= 1'b1;
      wd_r        <= 32'h0;
      bv_r        <= 1'b0;
      brsp_r      <= 2'b00;
      ar_r        <= 1'b0;
      rv_r        <= 1'b0;
      rd_r        <= 32'h0;
      rrsp_r      <= 2'b00;
    end else begin
      outs_r      <= outs_nxt;
      cnt_r       <= cnt_nxt;
      cfg_r       <= cfg_nxt;
      pend_r      <= pend_nxt;
      pend_v_r    <= pend_v_nxt;
      flags_r     <= flags_nxt;
      link_loss_r <= link_loss_nxt;
      pwr_thr_r   <= pwr_thr_nxt;
      writes_r    <= writes_nxt;
      key_r       <= key_nxt;
      keyed_r     <= keyed_nxt;
      vst_r       <= vst_nxt;
      vcnt_r      <= vcnt_nxt;
      vreq_r      <= vreq_nxt;
      ist_r       <= ist_nxt;
      imsk_r      <= imsk_nxt;
      irq_r       <= irq_nxt;
      awr_r       <= awr_nxt;
      awrdy_r     <= awrdy_nxt;
      awa_r       <= awa_nxt;
      wr_r        <= wr_nxt;
      wrdy_r      <= wrdy_nxt;
      wd_r        <= wd_nxt;
      bv_r        <= bv_nxt;
      brsp_r      <= brsp_nxt;
      ar_r        <= ar_nxt;
      rv_r        <= rv_nxt;
      rd_r        <= rd_nxt;
      rrsp_r      <= rrsp_nxt;
    end
  end

  assign s_axi_awready = awrdy_r;
  assign s_axi_wready  = wrdy_r;
  assign s_axi_bvalid  = bv_r;
  assign s_axi_bresp   = brsp_r;
  assign s_axi_arready = ar_r;
  assign s_axi_rvalid  = rv_r;
  assign s_axi_rdata   = rd_r;
  assign s_axi_rresp   = rrsp_r;
  assign outs          = outs_r;
  assign irq           = irq_r;

endmodule

//--- sim/ftcl_core_sva.sv
// Purpose: concurrent checks on the command outputs of ftcl_core
// Assumes: outputs move one cycle after the message edge, valid three cycles after
// Notes:   helper counters time the valid window and the distance to the last cause
`timescale 1ns/1ps
module ftcl_core_sva
  import ftcl_pkg::*;
#(
  parameter int unsigned VALID_ON  = VALID_ON_CYC,
  parameter int unsigned VALID_OFF = VALID_OFF_CYC
) (
  input wire logic      clk,
  input wire logic      rst,
  input wire logic      msg_valid,
  input wire ftcl_msg_t msg,
  input wire logic      s_axi_wvalid,
  input wire logic      s_axi_wready,
  input wire ftcl_out_t outs
);
  int unsigned on_r;
  int unsigned on_nxt;
  int unsigned off_r;
  int unsigned off_nxt;
  int unsigned since_r;
  int unsigned since_nxt;

  always_comb begin
    on_nxt    = outs.valid ? on_r + 1 : 0;
    off_nxt   = outs.valid ? 0 : ((off_r < VALID_OFF) ? off_r + 1 : off_r);
    since_nxt = (msg_valid || (s_axi_wvalid && s_axi_wready)) ? 0 :
                ((since_r < 8) ? since_r + 1 : since_r);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      on_r    <= 0;
      off_r   <= VALID_OFF;
      since_r <= 8;
    end else begin
      on_r    <= on_nxt;
      off_r   <= off_nxt;
      since_r <= since_nxt;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  // a latched output dropping needs a message or register write just before
  sequence s_drop;
    $fell(outs.arm) || $fell(outs.term) || $fell(outs.opt);
  endsequence

  property p_from(logic ev, ftcl_cmd_t c);
    ev |-> $past(msg_valid) && ($past(msg.cmd) == c);
  endproperty

  a_arm_cause: assert property (p_from($rose(outs.arm), FTCL_CMD_ARM))
    else $error("arm rose without an arm message");
  a_opt_cause: assert property (p_from($rose(outs.opt), FTCL_CMD_OPT))
    else $error("optional rose without an optional message");
  a_mon_cause: assert property (p_from(outs.mon, FTCL_CMD_MON))
    else $error("monitor pulse without a monitor message");
  a_chk_cause: assert property (outs.chk |-> $past(msg_valid) && $past(msg.check_channel))
    else $error("check pulse without a check-channel message");
  a_term_needs_arm: assert property ($rose(outs.term) |-> $past(outs.arm) && $past(msg_valid)
                                     && ($past(msg.cmd) == FTCL_CMD_TERM))
    else $error("terminate rose without arm latched");
  a_term_keeps_arm: assert property (outs.term |-> outs.arm)
    else $error("terminate high with arm low");
  a_latch_clear: assert property (s_drop |-> since_r <= 4)
    else $error("latched output dropped without a clearing event");
  a_valid_on: assert property ($fell(outs.valid) |-> on_r == VALID_ON)
    else $error("command valid on time wrong");
  a_valid_off: assert property ($rose(outs.valid) |-> off_r >= VALID_OFF
                                && $past(msg_valid, 3))
    else $error("command valid rose early or without a message");
endmodule

bind ftcl_core ftcl_core_sva #(.VALID_ON(VALID_ON), .VALID_OFF(VALID_OFF)) ftcl_core_sva_i (
  .clk(clk), .rst(rst), .msg_valid(msg_valid), .msg(msg),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .outs(outs));

//--- sim/ftcl_tx_model.sv
// Purpose: ground command transmitter feeding decoded messages
// Assumes: each message is one cycle; lines show the inverse value between frames
// Notes:   gap sets how soon the next message may follow
`timescale 1ns/1ps
module ftcl_tx_model
  import ftcl_pkg::*;
(
  input  wire logic clk,
  output logic      msg_valid,
  output ftcl_msg_t msg
);
  logic [15:0] seq_r;

  initial begin
    msg_valid = 1'b0;
    msg       = '0;
    seq_r     = 16'h0000;
  end

  task automatic send(input ftcl_cmd_t c, input logic chk, input logic [15:0] cnt,
                      input logic [3:0] slot, input int gap);
    ftcl_msg_t m;
    m         = '{cmd: c, check_channel: chk, counter: cnt, cfg_slot: slot};
    msg_valid <= 1'b1;
    msg       <= m;
    @(posedge clk);
    msg_valid <= 1'b0;
    msg       <= ~m;
    seq_r     <= seq_r + 16'h0001;
    repeat (gap) @(posedge clk);
  endtask

  // the counter field carries the value the receiver expects next
  task automatic clear_count(input logic [15:0] cur);
    send(FTCL_CMD_CNT_CLEAR, 1'b0, cur + 16'h0001, 4'h0, 2);
  endtask

  task automatic wireless_zero();
    send(FTCL_CMD_CFG_SELECT, 1'b0, seq_r, 4'h0, 3);
    send(FTCL_CMD_CFG_COMMIT, 1'b0, seq_r, 4'h0, 3);
  endtask
endmodule

//--- sim/tb_top.sv
// Purpose: self-checking bench of ftcl_core
// Assumes: shortened valid window of 20 on and 3 off cycles
// Notes:   registers reached over AXI4-Lite, messages from the transmitter model
`timescale 1ns/1ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin fails++; \
  $display("BAD t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
module tb_top;
  import ftcl_pkg::*;
  localparam int unsigned V_ON = 20;
  localparam logic [1:0] OK = 2'b00;
  localparam logic [31:0] KID = 32'h0000_5A17; // arbitrary key id
  logic clk, rst, msg_valid, key_load, key_zeroize, irq;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] key_load_id, s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  ftcl_msg_t msg;
  ftcl_out_t outs;
  int fails, comparisons;

  ftcl_core #(.VALID_ON(V_ON), .VALID_OFF(3)) ftcl_core_i (.clk(clk), .rst(rst),
    .msg_valid(msg_valid), .msg(msg), .key_load(key_load), .key_load_id(key_load_id),
    .key_zeroize(key_zeroize), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .outs(outs), .irq(irq));
  ftcl_tx_model ftcl_tx_model_i (.clk(clk), .msg_valid(msg_valid), .msg(msg));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic stop_test();
    $display("comparisons=%0d fails=%0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    s_axi_awaddr  <= {24'h000000, a};
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    for (n = 0; n < 200; n++) begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    if (n == 200) begin fails++; stop_test(); end
    `CHK(s_axi_bresp, OK)
    s_axi_bready <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                    input logic [1:0] er, output logic [31:0] v);
    int n;
    s_axi_araddr  <= {24'h000000, a};
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    for (n = 0; n < 200; n++) begin
      @(posedge clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    if (n == 200) begin fails++; stop_test(); end
    v = s_axi_rdata;
    `CHK(v & m, e)
    `CHK(s_axi_rresp, er)
    s_axi_rready <= 1'b0;
    @(posedge clk);
  endtask

  function automatic logic [2:0] lat();
    return {outs.arm, outs.term, outs.opt};
  endfunction

  task automatic snd(input ftcl_cmd_t c, input logic [3:0] slot);
    ftcl_tx_model_i.send(c, 1'b0, 16'h0000, slot, 3);
  endtask

  // counts pulse cycles of monitor, check and command valid while one message goes out
  task automatic watch(input ftcl_cmd_t c, input logic chk, output int m, output int k,
                       output int v);
    m = 0;
    k = 0;
    v = 0;
    fork
      ftcl_tx_model_i.send(c, chk, 16'h0000, 4'h0, 1);
      repeat (40) begin
        @(posedge clk);
        m += outs.mon;
        k += outs.chk;
        v += outs.valid;
      end
    join
  endtask

  task automatic t_defaults();
    logic [31:0] v;
    wr(OFF_CTRL, 32'h0000_0002);
    rd(OFF_CONFIG, 32'h0000_00FF, 32'h0000_00D0, OK, v);
    rd(OFF_FS, 32'hFFFF_FFFF, 32'h00E6_0005, OK, v);
    rd(OFF_WRITES, 32'h0000_FFFF, 32'h0000_FFFE, OK, v);
    rd(OFF_COUNTER, 32'hFFFF_FFFF, 32'h0000_0000, OK, v);
    rd(8'h24, 32'h0000_0000, 32'h0000_0000, 2'b10, v);
    snd(FTCL_CMD_ARM, 4'h0);
    `CHK(lat(), 3'b000)
    key_load <= 1'b1;
    @(posedge clk);
    key_load <= 1'b0;
    rd(OFF_KEY_ID, 32'hFFFF_FFFF, KID, OK, v);
  endtask

  task automatic t_latch();
    snd(FTCL_CMD_TERM, 4'h0);
    `CHK(lat(), 3'b000)
    snd(FTCL_CMD_ARM, 4'h0);
    snd(FTCL_CMD_ARM, 4'h0);
    `CHK(lat(), 3'b100)
    snd(FTCL_CMD_TERM, 4'h0);
    `CHK(lat(), 3'b110)
    snd(FTCL_CMD_OPT, 4'h0);
    snd(FTCL_CMD_TERM, 4'h0);
    repeat (30) @(posedge clk);
    `CHK(lat(), 3'b111)
    snd(FTCL_CMD_CLEAR_LATCHED_OUTPUTS_CMD, 4'h0);
    `CHK(lat(), 3'b000)
    snd(FTCL_CMD_OPT, 4'h0);
    wr(OFF_CTRL, 32'h0000_0001);
    `CHK(lat(), 3'b000)
  endtask

  task automatic t_pulse();
    int m, k, v;
    repeat (30) @(posedge clk);
    watch(FTCL_CMD_MON, 1'b0, m, k, v);
    `CHK(m, 1)
    `CHK(k, 0)
    `CHK(v, V_ON)
    watch(FTCL_CMD_NOP, 1'b1, m, k, v);
    `CHK({m, k}, {32'd0, 32'd1})
    `CHK(lat(), 3'b000)
  endtask

  task automatic t_counter();
    logic [31:0] v;
    rd(OFF_COUNTER, 32'h0000_0000, 32'h0000_0000, OK, v);
    ftcl_tx_model_i.clear_count(v[15:0]);
    rd(OFF_COUNTER, 32'hFFFF_FFFF, 32'h0000_0000, OK, v);
    snd(FTCL_CMD_ARM, 4'h0);
    ftcl_tx_model_i.wireless_zero();
    rd(OFF_COUNTER, 32'hFFFF_FFFF, 32'h0000_0000, OK, v);
    `CHK(lat(), 3'b100)
    snd(FTCL_CMD_MON, 4'h0);
    wr(OFF_CTRL, 32'h0000_0004);
    rd(OFF_COUNTER, 32'hFFFF_FFFF, 32'h0000_0000, OK, v);
    snd(FTCL_CMD_CFG_SELECT, 4'h1);
    snd(FTCL_CMD_CFG_COMMIT, 4'h1);
    `CHK(lat(), 3'b000)
    rd(OFF_CONFIG, 32'h0000_000F, 32'h0000_0001, OK, v);
  endtask

  task automatic t_irq();
    logic [31:0] v;
    wr(OFF_IRQ_ST, 32'h0000_003F);
    wr(OFF_IRQ_MSK, 32'h0000_0001);
    snd(FTCL_CMD_ARM, 4'h0);
    `CHK(irq, 1'b1)
    wr(OFF_IRQ_MSK, 32'h0000_0000);
    `CHK(irq, 1'b0)
    wr(OFF_IRQ_MSK, 32'h0000_0001);
    `CHK(irq, 1'b1)
    wr(OFF_IRQ_ST, 32'h0000_0001);
    rd(OFF_IRQ_ST, 32'h0000_0001, 32'h0000_0000, OK, v);
    `CHK(irq, 1'b0)
  endtask

  task automatic t_zeroize();
    logic [31:0] v;
    int m, k, n;
    repeat (30) @(posedge clk);
    key_zeroize <= 1'b1;
    @(posedge clk);
    key_zeroize <= 1'b0;
    rd(OFF_KEY_ID, 32'hFFFF_FFFF, KEY_ZERO_SENTINEL, OK, v);
    watch(FTCL_CMD_NOP, 1'b1, m, k, n);
    `CHK({k, n}, {32'd0, 32'd0})
  endtask

  initial begin
    fails = 0;
    comparisons = 0;
    rst = 1'b1;
    {key_load, key_zeroize, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready} = '0;
    {key_load_id, s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
    key_load_id = KID;
    s_axi_wstrb = 4'hF;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_defaults();
    t_latch();
    t_pulse();
    t_counter();
    t_irq();
    t_zeroize();
    stop_test();
  end
endmodule
